// ===== ssflm_pkg.sv
// constants shared by the serial flash lane map block and its fifo
// assumes an apb master with 32-bit data and byte addresses
package ssflm_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0c;
  localparam logic [7:0] OFS_ADDR   = 8'h10;
  localparam logic [7:0] OFS_MAP    = 8'h14;
  localparam logic [7:0] OFS_FLAGS  = 8'h18;

  // control register fields
  localparam int unsigned CTRL_PROTO_LSB = 0;
  localparam int unsigned CTRL_XCMD_LSB  = 2;
  localparam int unsigned CTRL_DIR_BIT   = 4;
  localparam logic [4:0]  CTRL_RST       = 5'h00;

  // protocol codes
  localparam logic [1:0] PROTO_EXTENDED_IO = 2'h0;
  localparam logic [1:0] PROTO_DUAL_IO     = 2'h1;
  localparam logic [1:0] PROTO_QUAD_IO     = 2'h2;

  // command width codes inside the extended protocol
  localparam logic [1:0] XCMD_SINGLE                = 2'h0;
  localparam logic [1:0] XCMD_DUAL                  = 2'h1;
  localparam logic [1:0] XCMD_QUAD_OUTPUT_FAST_READ = 2'h2;
  localparam logic [1:0] XCMD_QUAD_IO_FAST_READ     = 2'h3;

  // status register
  localparam int unsigned SR_WD_BIT  = 7;
  localparam logic [7:0]  SR_RST     = 8'h00;
  localparam logic [7:0]  SR_NV_MASK = 8'hfc;

  // address map
  localparam int unsigned ADDR_W    = 25;
  localparam int unsigned SECT_LSB  = 16;
  localparam int unsigned SUB32_LSB = 15;
  localparam int unsigned SUB4_LSB  = 12;
  localparam int unsigned MAP_SUB4_LSB  = 0;
  localparam int unsigned MAP_SUB32_LSB = 13;
  localparam int unsigned MAP_SECT_LSB  = 23;

  // flags register bits
  localparam int unsigned FLG_HWPROT  = 0;
  localparam int unsigned FLG_BLOCKED = 1;
  localparam int unsigned FLG_OVF     = 2;
  localparam int unsigned FLG_ARMED   = 3;
  localparam int unsigned FLG_CSACT   = 4;

  // receive fifo shape and read word layout
  localparam int unsigned FIFO_W       = 8;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned RX_VALID_BIT = 8;

  // lane counts per serial clock edge and bits per byte
  localparam logic [3:0] LANES_1 = 4'h1;
  localparam logic [3:0] LANES_2 = 4'h2;
  localparam logic [3:0] LANES_4 = 4'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage

// ===== ssflm_fifo.sv
// small synchronous fifo in flip-flops with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
module ssflm_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // honest full and empty from the fill count
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH)); // count is one bit wider than the pointers
  assign out_valid_o = (cnt_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_q];

  // storage, written only on an accepted push
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== ssflm_top.sv
// device-side lane mapper, write-protect gate and address map decoder
// assumes an apb master on CORE_CLK_I and a serial host on the pins
// Overview of operation
// - write-disable bit set and protect pin low: status write refused, bits frozen
// - protect pin doubles as data lane 2 in quad fast reads and quad protocol
// - single-lane extended commands: host sends on lane 0, device answers on lane 1
// - dual commands and dual protocol: lanes 1 and 0 bidirectional, 3 and 2 idle
// - quad commands and quad protocol: all four lanes carry data
// - byte addresses 0 to 01ffffffh, 512 sectors of 64KB, 511 highest
// - sectors split into 32KB and 4KB subsectors, ascending with address
// - hardware protection ends only when the protect pin goes high
// - write-disable is status bit 7, zero after reset permits writes
// - falling select edge needed after reset; deselected device ignores and floats
module ssflm_top
  import ssflm_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        SCLK_I,
  input  wire logic        CS_N_I,
  input  wire logic [3:0]  DQ_I,
  output logic [3:0]       DQ_O,
  output logic [3:0]       DQ_OE_O
);

  typedef enum logic [1:0] {ST_UNARMED, ST_IDLE, ST_FRAME} ssflm_state_t;

  ssflm_state_t      state_q;
  logic [5:0]        pin_s1_q;
  logic [5:0]        pin_s2_q;
  logic              sclk_s3_q;
  logic              cs_n_s3_q;
  logic              sclk_s;
  logic              cs_n_s;
  logic [3:0]        dq_s;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              cs_fall;
  logic [4:0]        ctrl_q;
  logic [1:0]        proto;
  logic [1:0]        xcmd;
  logic              dir_out;
  logic [3:0]        lane_n;
  logic [3:0]        lane_mask;
  logic [7:0]        sr_q;
  logic              wp_lvl_q;
  logic              hw_prot;
  logic [ADDR_W-1:0] addr_q;
  logic [8:0]        sect_idx;
  logic [9:0]        sub32_idx;
  logic [12:0]       sub4_idx;
  logic [7:0]        txdata_q;
  logic [7:0]        tx_sh_q;
  logic [3:0]        tx_cnt_q;
  logic [3:0]        tx_cnt_nx;
  logic [3:0]        dq_o_q;
  logic [7:0]        rx_sh_q;
  logic [7:0]        rx_sh_d;
  logic [3:0]        rx_cnt_q;
  logic [3:0]        rx_cnt_nx;
  logic              rx_push;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [7:0]        fifo_out_data;
  logic              rx_pop;
  logic              blocked_q;
  logic              ovf_q;
  logic              apb_setup;
  logic              apb_wr;
  logic              apb_rd;
  logic              sr_wr_req;
  logic              flg_wr;
  logic [31:0]       rdata_q;
  logic              err_q;
  logic              map_hit;
  logic [31:0]       rd_mux;

  // two-stage synchronisers for every pin; stage one feeds stage two only
  // select stages reset as asserted: a select held low through reset is no fall
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      pin_s1_q  <= 6'h10;
      pin_s2_q  <= 6'h10;
      sclk_s3_q <= 1'b1; // matches the idle-high clock, no false rise
      cs_n_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q  <= {CS_N_I, SCLK_I, DQ_I};
      pin_s2_q  <= pin_s1_q;
      sclk_s3_q <= pin_s2_q[4];
      cs_n_s3_q <= pin_s2_q[5];
    end
  end

  assign cs_n_s    = pin_s2_q[5];
  assign sclk_s    = pin_s2_q[4];
  assign dq_s      = pin_s2_q[3:0];
  assign sclk_rise = sclk_s && !sclk_s3_q;
  assign sclk_fall = !sclk_s && sclk_s3_q;
  assign cs_fall   = cs_n_s3_q && !cs_n_s;

  // frame tracking; nothing moves until a select falling edge after reset
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      state_q <= ST_UNARMED;
    end
    else
    begin
      case (state_q)
        ST_UNARMED: if (cs_fall) state_q <= ST_FRAME;
        ST_IDLE:    if (cs_fall) state_q <= ST_FRAME;
        ST_FRAME:   if (cs_n_s) state_q <= ST_IDLE;
        default:    state_q <= ST_UNARMED;
      endcase
    end
  end

  assign proto   = ctrl_q[CTRL_PROTO_LSB +: 2];
  assign xcmd    = ctrl_q[CTRL_XCMD_LSB +: 2];
  assign dir_out = ctrl_q[CTRL_DIR_BIT];

  // lane count and drive mask from protocol and command width
  always_comb
  begin
    lane_n    = LANES_1;
    lane_mask = 4'h2;
    case (proto)
      PROTO_DUAL_IO:
      begin
        lane_n    = LANES_2;
        lane_mask = 4'h3;
      end
      PROTO_QUAD_IO:
      begin
        lane_n    = LANES_4;
        lane_mask = 4'hf;
      end
      default:
      begin
        case (xcmd)
          XCMD_SINGLE:
          begin
            lane_n    = LANES_1;
            lane_mask = 4'h2;
          end
          XCMD_DUAL:
          begin
            lane_n    = LANES_2;
            lane_mask = 4'h3;
          end
          default:
          begin
            lane_n    = LANES_4;
            lane_mask = 4'hf;
          end
        endcase
      end
    endcase
  end

  // drive only inside a frame and only while returning data
  assign DQ_OE_O = (state_q == ST_FRAME && dir_out) ? lane_mask : 4'h0;
  assign DQ_O    = dq_o_q;

  // receive shifter: width follows the lane count, lane 0 alone when single
  always_comb
  begin
    case (lane_n)
      LANES_1: rx_sh_d = {rx_sh_q[6:0], dq_s[0]};
      LANES_2: rx_sh_d = {rx_sh_q[5:0], dq_s[1:0]};
      default: rx_sh_d = {rx_sh_q[3:0], dq_s[3:0]};
    endcase
  end

  assign rx_cnt_nx = rx_cnt_q + lane_n;
  assign rx_push   = (state_q == ST_FRAME) && !dir_out && sclk_rise
                     && (rx_cnt_nx == BITS_PER_BYTE);

  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rx_sh_q  <= 8'h00;
      rx_cnt_q <= 4'h0;
    end
    else if (state_q != ST_FRAME)
    begin
      rx_cnt_q <= 4'h0;
    end
    else if (sclk_rise && !dir_out)
    begin
      rx_sh_q  <= rx_sh_d;
      rx_cnt_q <= (rx_cnt_nx == BITS_PER_BYTE) ? 4'h0 : rx_cnt_nx;
    end
  end

  // the serial host cannot be stalled, so a full fifo loses the byte
  ssflm_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (CORE_CLK_I),
    .nrst_i      (NRST_I),
    .in_valid_i  (rx_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rx_sh_d),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (rx_pop),
    .out_data_o  (fifo_out_data)
  );

  // transmit: shift out on falling serial clock, reload each byte
  assign tx_cnt_nx = tx_cnt_q + lane_n;

  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      tx_sh_q  <= 8'h00;
      tx_cnt_q <= 4'h0;
      dq_o_q   <= 4'h0;
    end
    else if (state_q != ST_FRAME)
    begin
      tx_sh_q  <= txdata_q;
      tx_cnt_q <= 4'h0;
    end
    else if (sclk_fall && dir_out)
    begin
      case (lane_n)
        LANES_1: dq_o_q <= {2'b00, tx_sh_q[7], 1'b0};
        LANES_2: dq_o_q <= {2'b00, tx_sh_q[7:6]};
        default: dq_o_q <= tx_sh_q[7:4];
      endcase
      if (tx_cnt_nx == BITS_PER_BYTE)
      begin
        tx_sh_q  <= txdata_q;
        tx_cnt_q <= 4'h0;
      end
      else
      begin
        tx_sh_q  <= tx_sh_q << lane_n;
        tx_cnt_q <= tx_cnt_nx;
      end
    end
  end

  // protect pin level; frozen while the pin serves as data lane 2
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      wp_lvl_q <= 1'b0;
    end
    else if (!(state_q == ST_FRAME && lane_n == LANES_4))
    begin
      wp_lvl_q <= dq_s[2];
    end
  end

  // protection is released only by the pin, bit 7 cannot drop meanwhile
  assign hw_prot = sr_q[SR_WD_BIT] && !wp_lvl_q;

  // apb decode; the slave never waits
  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_wr    = PSEL_I && PENABLE_I && PWRITE_I;
  assign apb_rd    = PSEL_I && PENABLE_I && !PWRITE_I;
  assign sr_wr_req = apb_wr && PADDR_I == OFS_STATUS;
  assign flg_wr    = apb_wr && PADDR_I == OFS_FLAGS;
  assign rx_pop    = apb_rd && PADDR_I == OFS_RXDATA && fifo_out_valid;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = err_q && PSEL_I && PENABLE_I;
  assign PRDATA_O  = rdata_q;

  // software-written control, transmit byte and address
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ctrl_q   <= CTRL_RST;
      txdata_q <= 8'h00;
      addr_q   <= '0;
    end
    else if (apb_wr)
    begin
      case (PADDR_I)
        OFS_CTRL:   ctrl_q   <= PWDATA_I[4:0];
        OFS_TXDATA: txdata_q <= PWDATA_I[7:0];
        OFS_ADDR:   addr_q   <= PWDATA_I[ADDR_W-1:0];
        default:    ;
      endcase
    end
  end

  // status register: nonvolatile bits only, whole write refused when protected
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      sr_q <= SR_RST;
    end
    else if (sr_wr_req && !hw_prot)
    begin
      sr_q <= PWDATA_I[7:0] & SR_NV_MASK;
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      blocked_q <= 1'b0;
      ovf_q     <= 1'b0;
    end
    else
    begin
      if (sr_wr_req && hw_prot)
        blocked_q <= 1'b1;
      else if (flg_wr && PWDATA_I[FLG_BLOCKED])
        blocked_q <= 1'b0;
      if (rx_push && !fifo_in_ready)
        ovf_q <= 1'b1;
      else if (flg_wr && PWDATA_I[FLG_OVF])
        ovf_q <= 1'b0;
    end
  end

  // map indices are plain slices of the address
  assign sect_idx  = addr_q[ADDR_W-1:SECT_LSB];
  assign sub32_idx = addr_q[ADDR_W-1:SUB32_LSB];
  assign sub4_idx  = addr_q[ADDR_W-1:SUB4_LSB];

  // read mux sampled in the setup phase so the data comes from a flop
  always_comb
  begin
    rd_mux  = 32'h0000_0000;
    map_hit = 1'b1;
    case (PADDR_I)
      OFS_CTRL:   rd_mux[4:0] = ctrl_q;
      OFS_STATUS: rd_mux[7:0] = sr_q;
      OFS_TXDATA: rd_mux[7:0] = txdata_q;
      OFS_RXDATA: rd_mux[8:0] = {fifo_out_valid, fifo_out_data};
      OFS_ADDR:   rd_mux[ADDR_W-1:0] = addr_q;
      OFS_MAP:
      begin
        rd_mux[MAP_SUB4_LSB +: 13] = sub4_idx;
        rd_mux[MAP_SUB32_LSB +: 10] = sub32_idx;
        rd_mux[MAP_SECT_LSB +: 9] = sect_idx;
      end
      OFS_FLAGS:
      begin
        rd_mux[FLG_HWPROT]  = hw_prot;
        rd_mux[FLG_BLOCKED] = blocked_q;
        rd_mux[FLG_OVF]     = ovf_q;
        rd_mux[FLG_ARMED]   = (state_q != ST_UNARMED);
        rd_mux[FLG_CSACT]   = (state_q == ST_FRAME);
      end
      default:    map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
    else if (apb_setup)
    begin
      rdata_q <= PWRITE_I ? 32'h0000_0000 : rd_mux;
      err_q   <= !map_hit;
    end
  end

  sequence s_addr_write;
    apb_wr && PADDR_I == OFS_ADDR;
  endsequence

  sequence s_prot_write;
    sr_wr_req && hw_prot;
  endsequence

  AST_WSR_REFUSED: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    s_prot_write |=> $stable(sr_q) && blocked_q)
    else $error("status changed while hardware protected");

  AST_LANE2_QUAD: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    DQ_OE_O[2] |-> lane_n == LANES_4 && (proto == PROTO_QUAD_IO || xcmd[1]))
    else $error("lane 2 driven outside quad use");

  AST_SINGLE_LANE: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    lane_n == LANES_1 |-> (DQ_OE_O & 4'hd) == 4'h0)
    else $error("single mode drives a lane other than 1");

  AST_DUAL_LANES: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    lane_n == LANES_2 |-> DQ_OE_O[3:2] == 2'b00)
    else $error("dual mode drives lanes 3 or 2");

  AST_QUAD_ALL: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    state_q == ST_FRAME && dir_out && lane_n == LANES_4 |-> DQ_OE_O == 4'hf)
    else $error("quad mode does not drive all lanes");

  AST_ADDR_MAP: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    s_addr_write ##1 !apb_wr |-> sect_idx == $past(PWDATA_I[24:16], 2))
    else $error("sector index does not follow written address");

  AST_SUB_NEST: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    sub4_idx[12:3] == sub32_idx && sub32_idx[9:1] == sect_idx)
    else $error("subsector indices do not nest");

  AST_PROT_EXIT: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    $fell(hw_prot) |-> wp_lvl_q)
    else $error("protection left without protect pin high");

  AST_FLOAT_DESEL: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
    state_q != ST_FRAME |-> DQ_OE_O == 4'h0)
    else $error("outputs driven while deselected or unarmed");

endmodule

// ===== ssflm_host_model.sv
// host-side serial flash controller model: select, clock, lanes
// assumes the bench resolves each lane from both parties' enables
module ssflm_host_model
(
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic [3:0]      dq_o,
  output logic [3:0]      dq_oe_o,
  input  wire logic [3:0] dq_i
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam time HALF = 24ns;
  logic wp_q;

  // clock idles high, select starts low so the first fall must be made
  initial
  begin
    sclk_o = 1'b1;
    cs_n_o = 1'b0;
    wp_q = 1'b1;
    dq_o = 4'b1100;
    dq_oe_o = 4'b1100;
  end

  // select edges with a level held well beyond the sampler's needs
  task automatic select(input logic on);
    #HALF cs_n_o = ~on;
    #HALF;
  endtask

  // protect pin level, driven outside quad reads since it has no pull-up
  task automatic set_wp(input logic v);
    wp_q = v;
    dq_o[2] = v;
  endtask

  // one byte msb first; drive on falling, sample on rising
  task automatic shift(input int lanes, input logic rd, input logic [7:0] tx, output logic [7:0] rx);
    logic [7:0] sh;
    logic [3:0] m;
    sh = tx;
    rx = 8'h00;
    m = (lanes == 4) ? 4'hf : (lanes == 2) ? 4'h3 : 4'h1;
    for (int k = 0; k < 8 / lanes; k++)
    begin
      #HALF sclk_o = 1'b0;
      if (rd)
        dq_oe_o = (lanes == 4) ? 4'h0 : 4'b1100;
      else
      begin
        dq_oe_o = (lanes == 1) ? 4'b1101 : 4'hf;
        dq_o = (lanes == 4) ? sh[7:4] : (lanes == 2) ? {1'b1, wp_q, sh[7:6]} : {1'b1, wp_q, 1'b0, sh[7]};
      end
      #HALF sclk_o = 1'b1;
      rx = (rx << lanes) | ((lanes == 1) ? {7'h0, dq_i[1]} : {4'h0, dq_i & m});
      sh = sh << lanes;
    end
    #HALF; // hold the last bit until the device has sampled it
    dq_oe_o = 4'b1100;
    dq_o = {1'b1, wp_q, 2'b00};
  endtask
endmodule

// ===== ssflm_top_tb.sv
// self-checking bench for the lane mapper, protect gate and map decoder
// assumes the host model on the pins and an apb master task on the core clock
module ssflm_top_tb
  import ssflm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk = 1'b0;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk;
  logic        cs_n;
  logic [3:0]  h_dq;
  logic [3:0]  h_oe;
  logic [3:0]  d_dq;
  logic [3:0]  d_oe;
  logic [3:0]  dq_w;
  logic        float_q = 1'b0;
  int          miscompares = 0;
  int          total_checks = 0;
  logic [31:0] d;
  logic        e;
  logic [7:0]  rx;
  logic [31:0] a;
  logic [1:0]  pr [6] = '{PROTO_EXTENDED_IO, PROTO_EXTENDED_IO, PROTO_EXTENDED_IO, PROTO_EXTENDED_IO,
                          PROTO_DUAL_IO, PROTO_QUAD_IO};
  logic [1:0]  xc [6] = '{XCMD_SINGLE, XCMD_DUAL, XCMD_QUAD_OUTPUT_FAST_READ, XCMD_QUAD_IO_FAST_READ,
                          XCMD_SINGLE, XCMD_SINGLE};
  int          ln [6] = '{1, 2, 4, 4, 2, 4};
  logic [3:0]  om [6] = '{4'b0010, 4'b0011, 4'hf, 4'hf, 4'b0011, 4'hf};
  logic [31:0] at [7] = '{32'h0, 32'h7fff, 32'h8000, 32'hf000, 32'hff7000, 32'h1ff0fff, 32'h1ffffff};

  always #2.5 core_clk = ~core_clk;

  // released lanes wander instead of holding the last value
  always @(posedge core_clk) float_q <= ~float_q;
  always_comb
    for (int i = 0; i < 4; i++)
      dq_w[i] = h_oe[i] ? h_dq[i] : d_oe[i] ? d_dq[i] : float_q;

  ssflm_top u_dut (
    .CORE_CLK_I (core_clk),
    .NRST_I     (nrst),
    .PSEL_I     (psel),
    .PENABLE_I  (penable),
    .PWRITE_I   (pwrite),
    .PADDR_I    (paddr),
    .PWDATA_I   (pwdata),
    .PRDATA_O   (prdata),
    .PREADY_O   (pready),
    .PSLVERR_O  (pslverr),
    .SCLK_I     (sclk),
    .CS_N_I     (cs_n),
    .DQ_I       (dq_w),
    .DQ_O       (d_dq),
    .DQ_OE_O    (d_oe)
  );

  ssflm_host_model u_host (
    .sclk_o  (sclk),
    .cs_n_o  (cs_n),
    .dq_o    (h_dq),
    .dq_oe_o (h_oe),
    .dq_i    (dq_w)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits for pready under a bounded count
  task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= w;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    if (n >= 100)
      miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] t;
    logic te;
    apb(ad, 1'b1, wd, t, te);
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] t;
    logic te;
    apb(ad, 1'b0, 32'h0, t, te);
    check(t & m, exp);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, far above the expected run length
  initial
  begin
    #200us;
    miscompares++;
    conclude;
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, nrst} = '0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    rd_chk(OFS_STATUS, 32'h0, 32'hff);
    rd_chk(OFS_FLAGS, 32'h0, 32'h9);
    apb(8'h1c, 1'b0, 32'h0, d, e);
    check({d[30:0], e}, 32'h1);
    // select never fell since reset: the byte must be ignored
    u_host.shift(1, 1'b0, 8'h5a, rx);
    repeat (8) @(posedge core_clk);
    rd_chk(OFS_RXDATA, 32'h0, 32'h100);
    check({28'h0, d_oe}, 32'h0);
    // raise select so the first frame below opens with a real fall
    u_host.select(1'b0);
    rd_chk(OFS_FLAGS, 32'h0, 32'h8);
    // every protocol and width code, both directions
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_CTRL, {27'h0, 1'b0, xc[i], pr[i]});
      u_host.select(1'b1);
      u_host.shift(ln[i], 1'b0, 8'h3c ^ 8'(i), rx);
      check({28'h0, d_oe}, 32'h0);
      u_host.select(1'b0);
      rd_chk(OFS_RXDATA, {23'h0, 1'b1, 8'h3c ^ 8'(i)}, 32'h1ff);
      wr(OFS_CTRL, {27'h0, 1'b1, xc[i], pr[i]});
      wr(OFS_TXDATA, 32'h96 + i);
      u_host.select(1'b1);
      u_host.shift(ln[i], 1'b1, 8'h00, rx);
      check({24'h0, rx}, 32'h96 + i);
      check({28'h0, d_oe}, {28'h0, om[i]});
      u_host.select(1'b0);
      repeat (8) @(posedge core_clk);
      check({28'h0, d_oe}, 32'h0);
    end
    // protect gate: bit 7 with the pin low freezes status
    wr(OFS_STATUS, 32'h80);
    rd_chk(OFS_STATUS, 32'h80, 32'hff);
    u_host.set_wp(1'b0);
    repeat (4) @(posedge core_clk);
    rd_chk(OFS_FLAGS, 32'h1, 32'h1);
    wr(OFS_STATUS, 32'h3c);
    rd_chk(OFS_STATUS, 32'h80, 32'hff);
    rd_chk(OFS_FLAGS, 32'h2, 32'h2);
    wr(OFS_STATUS, 32'h0);
    rd_chk(OFS_STATUS, 32'h80, 32'hff);
    u_host.set_wp(1'b1);
    repeat (4) @(posedge core_clk);
    rd_chk(OFS_FLAGS, 32'h0, 32'h1);
    wr(OFS_STATUS, 32'h7c);
    rd_chk(OFS_STATUS, 32'h7c, 32'hff);
    u_host.set_wp(1'b0);
    wr(OFS_STATUS, 32'h04);
    rd_chk(OFS_STATUS, 32'h04, 32'hff);
    u_host.set_wp(1'b1);
    wr(OFS_FLAGS, 32'h6);
    rd_chk(OFS_FLAGS, 32'h0, 32'h6);
    // map boundaries, expected indices from the region sizes
    for (int i = 0; i < 7; i++)
    begin
      a = at[i];
      wr(OFS_ADDR, a);
      rd_chk(OFS_MAP, ((a / 32'h10000) << 23) | ((a / 32'h8000) << 13) | (a / 32'h1000), '1);
    end
    rd_chk(OFS_MAP, {9'd511, 10'd1023, 13'd8191}, '1);
    // fill the fifo past full with no reads, then drain it dry
    wr(OFS_CTRL, {30'h0, PROTO_QUAD_IO});
    u_host.select(1'b1);
    for (int i = 0; i < 17; i++)
      u_host.shift(4, 1'b0, 8'(i + 1), rx);
    u_host.select(1'b0);
    rd_chk(OFS_FLAGS, 32'h4, 32'h4);
    for (int i = 0; i < 16; i++)
      rd_chk(OFS_RXDATA, {23'h0, 1'b1, 8'(i + 1)}, 32'h1ff);
    rd_chk(OFS_RXDATA, 32'h0, 32'h100);
    conclude;
  end
endmodule
